// ==== src/bdl_defs.vh ====
`ifndef BDL_DEFS_VH
`define BDL_DEFS_VH

// Sigma-delta word width and decimation ratio
`define BDL_SD_W        2
`define BDL_DECIM       24
// Output sample width and discarded pairs after conversion start
`define BDL_SMP_W       12
`define BDL_DISCARD     8
// Analog power-on settling time (ns) and derived clock count at 10 MHz
`define BDL_CLK_NS      100
`define BDL_SETTLE_NS   20000
`define BDL_SETTLE_CYC  ((`BDL_SETTLE_NS + `BDL_CLK_NS - 1) / `BDL_CLK_NS)
// Offset register reset value
`define BDL_OFS_RST     12'h000
// Sequencer states
`define BDL_ST_OFF      2'h0
`define BDL_ST_SETTLE   2'h1
`define BDL_ST_ON       2'h2

`endif

// ==== src/bdl_decim.v ====
`timescale 1ns/10ps
`default_nettype none
`include "bdl_defs.vh"
// One channel: decimating accumulator with offset register
module bdl_decim #(
	parameter DECIM = `BDL_DECIM,
	parameter SMP_W = `BDL_SMP_W
) (
	input  wire               clk,
	input  wire               rst_n,
	input  wire               ce,
	input  wire               run,
	input  wire               sd_valid,
	input  wire [1:0]         sd_word,
	input  wire               cal_store,
	output reg  [SMP_W-1:0]   sample_r,
	output reg                sample_vld_r,
	output reg  [SMP_W-1:0]   offset_r
);
	reg  [4:0]       phase_r;
	reg  [SMP_W-1:0] acc_r;
	wire [SMP_W-1:0] word_ext;
	wire [SMP_W-1:0] acc_nxt;
	wire             last;

	// Two-bit code is signed, sign extended into the accumulator
	assign word_ext = {{(SMP_W-2){sd_word[1]}}, sd_word};
	assign acc_nxt  = acc_r + word_ext;
	assign last     = (phase_r == DECIM - 1);

	// Boxcar decimator; restarts each time the path stops running
	always @(posedge clk) begin
		if (!rst_n) begin
			phase_r      <= 5'h00;
			acc_r        <= {SMP_W{1'b0}};
			sample_r     <= {SMP_W{1'b0}};
			sample_vld_r <= 1'b0;
			offset_r     <= `BDL_OFS_RST;
		end else if (ce) begin
			sample_vld_r <= 1'b0;
			if (!run) begin
				phase_r <= 5'h00;
				acc_r   <= {SMP_W{1'b0}};
			end else if (sd_valid) begin
				if (last) begin
					phase_r      <= 5'h00;
					acc_r        <= {SMP_W{1'b0}};
					sample_r     <= acc_nxt - offset_r;
					sample_vld_r <= 1'b1;
					// Raw result of a calibration conversion becomes offset
					if (cal_store)
						offset_r <= acc_nxt;
				end else begin
					phase_r <= phase_r + 5'h01;
					acc_r   <= acc_nxt;
				end
			end
		end
	end
endmodule // bdl_decim
`default_nettype wire

// ==== src/bdl_rx_ctrl.v ====
// Summary of operation
// - Two identical I and Q channels
// - Converter delivers 2-bit words at 6.5 MHz
// - Decimate each channel by 24
// - Subtract stored offset from every sample
// - Offsets reset to zero, changed by calibration
// - Power window high powers path after settling
// - Calibrate both channels during calibration window
// - Source select 0 shorts inputs internally
// - Source select 1 keeps external inputs
// - Drop first eight pairs after conversion start
// - Conversion start routes serial transmit to uplink
// - On window fall finish current sample, stop
// - Power window low powers path down
// - Corrected samples go out on serial port
`timescale 1ns/10ps
`default_nettype none
`include "bdl_defs.vh"
module bdl_rx_ctrl #(
	parameter SMP_W      = `BDL_SMP_W,
	parameter SETTLE_CYC = `BDL_SETTLE_CYC
) (
	input  wire               clk,
	input  wire               rst_n,
	input  wire               ce,
	input  wire               downlink_power_window,
	input  wire               downlink_calibration_window,
	input  wire               downlink_conversion_window,
	input  wire               calibration_source_select,
	input  wire               sd_valid,
	input  wire [1:0]         sd_i_word,
	input  wire [1:0]         sd_q_word,
	output reg                analog_power_on_r,
	output wire               input_short,
	output reg                tx_to_uplink_r,
	output reg  [SMP_W-1:0]   baseband_serial_port_i,
	output reg  [SMP_W-1:0]   baseband_serial_port_q,
	output reg                baseband_serial_port_vld,
	output wire [SMP_W-1:0]   offset_i,
	output wire [SMP_W-1:0]   offset_q,
	output wire               powered,
	output wire               calibrating,
	output wire               converting
);
	// Three-stage synchronisers; stage 1 is only read by stage 2
	reg  [2:0] pw_s_r;
	reg  [2:0] cw_s_r;
	reg  [2:0] vw_s_r;
	reg        pw_r;
	reg        cw_r;
	reg        vw_r;
	reg  [1:0] state_r;
	reg  [31:0] settle_r;
	reg        conv_r;
	reg        stop_r;
	reg  [3:0] drop_r;
	wire       pw_rise;
	wire       pw_fall;
	wire       vw_rise;
	wire       vw_fall;
	wire       on;
	wire       cal_run;
	wire       run;
	wire       vld_i;
	wire       vld_q;
	wire [SMP_W-1:0] smp_i;
	wire [SMP_W-1:0] smp_q;

	// Level counts once stages two and three agree
	always @(posedge clk) begin
		if (!rst_n) begin
			pw_s_r <= 3'h0;
			cw_s_r <= 3'h0;
			vw_s_r <= 3'h0;
			pw_r   <= 1'b0;
			cw_r   <= 1'b0;
			vw_r   <= 1'b0;
		end else if (ce) begin
			pw_s_r <= {pw_s_r[1:0], downlink_power_window};
			cw_s_r <= {cw_s_r[1:0], downlink_calibration_window};
			vw_s_r <= {vw_s_r[1:0], downlink_conversion_window};
			if (pw_s_r[1] == pw_s_r[2])
				pw_r <= pw_s_r[2];
			if (cw_s_r[1] == cw_s_r[2])
				cw_r <= cw_s_r[2];
			if (vw_s_r[1] == vw_s_r[2])
				vw_r <= vw_s_r[2];
		end
	end

	// Edges from successive filtered levels
	assign pw_rise = (pw_s_r[1] == pw_s_r[2]) & pw_s_r[2] & ~pw_r;
	assign pw_fall = (pw_s_r[1] == pw_s_r[2]) & ~pw_s_r[2] & pw_r;
	assign vw_rise = (vw_s_r[1] == vw_s_r[2]) & vw_s_r[2] & ~vw_r;
	assign vw_fall = (vw_s_r[1] == vw_s_r[2]) & ~vw_s_r[2] & vw_r;

	// Power sequencer: settling delay, then on; drop ends everything
	always @(posedge clk) begin
		if (!rst_n) begin
			state_r           <= `BDL_ST_OFF;
			settle_r          <= 32'h0;
			analog_power_on_r <= 1'b0;
		end else if (ce) begin
			case (state_r)
			`BDL_ST_OFF: begin
				if (pw_rise) begin
					analog_power_on_r <= 1'b1;
					settle_r          <= 32'h0;
					state_r           <= `BDL_ST_SETTLE;
				end
			end
			`BDL_ST_SETTLE: begin
				if (pw_fall) begin
					analog_power_on_r <= 1'b0;
					state_r           <= `BDL_ST_OFF;
				end else if (settle_r >= SETTLE_CYC - 1) begin
					state_r <= `BDL_ST_ON;
				end else begin
					settle_r <= settle_r + 32'h1;
				end
			end
			`BDL_ST_ON: begin
				if (pw_fall) begin
					analog_power_on_r <= 1'b0;
					state_r           <= `BDL_ST_OFF;
				end
			end
			default: begin
				state_r           <= `BDL_ST_OFF;
				analog_power_on_r <= 1'b0;
			end
			endcase
		end
	end

	assign on      = (state_r == `BDL_ST_ON);
	// Windows count only while the path is powered and settled
	assign cal_run = on & cw_r & ~conv_r;
	// Internal short only when calibrating from the shorted inputs
	assign input_short = cal_run & ~calibration_source_select;

	// Conversion control; a fall lets the current sample finish
	always @(posedge clk) begin
		if (!rst_n) begin
			conv_r         <= 1'b0;
			stop_r         <= 1'b0;
			drop_r         <= 4'h0;
			tx_to_uplink_r <= 1'b0;
		end else if (ce) begin
			// Power loss ends a conversion at once, not after the sample
			if (!on || pw_fall) begin
				conv_r         <= 1'b0;
				stop_r         <= 1'b0;
				tx_to_uplink_r <= 1'b0;
			end else if (vw_rise && !conv_r) begin
				conv_r         <= 1'b1;
				stop_r         <= 1'b0;
				drop_r         <= 4'h0;
				tx_to_uplink_r <= 1'b1;
			end else if (conv_r) begin
				if (vw_fall)
					stop_r <= 1'b1;
				if (vld_i) begin
					if (drop_r != `BDL_DISCARD)
						drop_r <= drop_r + 4'h1;
					if (stop_r || vw_fall) begin
						conv_r         <= 1'b0;
						stop_r         <= 1'b0;
						tx_to_uplink_r <= 1'b0;
					end
				end
			end
		end
	end

	assign run = cal_run | conv_r;

	// Identical I and Q channels
	bdl_decim #(.DECIM(`BDL_DECIM), .SMP_W(SMP_W)) u_chan_i (
		.clk          (clk),
		.rst_n        (rst_n),
		.ce           (ce),
		.run          (run),
		.sd_valid     (sd_valid),
		.sd_word      (sd_i_word),
		.cal_store    (cal_run),
		.sample_r     (smp_i),
		.sample_vld_r (vld_i),
		.offset_r     (offset_i)
	);
	bdl_decim #(.DECIM(`BDL_DECIM), .SMP_W(SMP_W)) u_chan_q (
		.clk          (clk),
		.rst_n        (rst_n),
		.ce           (ce),
		.run          (run),
		.sd_valid     (sd_valid),
		.sd_word      (sd_q_word),
		.cal_store    (cal_run),
		.sample_r     (smp_q),
		.sample_vld_r (vld_q),
		.offset_r     (offset_q)
	);

	// Forward corrected pairs after the discard count
	always @(posedge clk) begin
		if (!rst_n) begin
			baseband_serial_port_i   <= {SMP_W{1'b0}};
			baseband_serial_port_q   <= {SMP_W{1'b0}};
			baseband_serial_port_vld <= 1'b0;
		end else if (ce) begin
			baseband_serial_port_vld <= 1'b0;
			if (conv_r && vld_i && vld_q && drop_r == `BDL_DISCARD) begin
				baseband_serial_port_i   <= smp_i;
				baseband_serial_port_q   <= smp_q;
				baseband_serial_port_vld <= 1'b1;
			end
		end
	end

	assign powered     = on;
	assign calibrating = cal_run;
	assign converting  = conv_r;
endmodule // bdl_rx_ctrl
`default_nettype wire

// ==== verif/bdl_rx_props.sv ====
`timescale 1ns/10ps
`default_nettype none
// Port-level timing relations of the receive controller
module bdl_rx_props #(
	parameter SMP_W = 12,
	parameter SETTLE_CYC = 4
) (
	input wire logic		clk,
	input wire logic		rst_n,
	input wire logic		downlink_power_window,
	input wire logic		calibration_source_select,
	input wire logic		analog_power_on_r,
	input wire logic		input_short,
	input wire logic		tx_to_uplink_r,
	input wire logic		baseband_serial_port_vld,
	input wire logic [SMP_W-1:0]	offset_i,
	input wire logic [SMP_W-1:0]	offset_q,
	input wire logic		powered,
	input wire logic		calibrating,
	input wire logic		converting
);
	// Settle bound; one spare cycle covers the status decode
	localparam int SHI = SETTLE_CYC + 1;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	AST_OFS_RST: assert property ($rose(rst_n) |-> !(|{offset_i, offset_q}))
		else $error("offsets not clear after reset");
	AST_OFS_HOLD: assert property ($changed(offset_i) || $changed(offset_q)
		|-> $past(calibrating) || $past(calibrating, 2))
		else $error("offset changed outside calibration");
	AST_PWR_UP: assert property ($rose(analog_power_on_r)
		|-> !powered [*3] ##[1:SHI] powered)
		else $error("power-on settle time wrong");
	AST_PWR_DN: assert property ($fell(downlink_power_window)
		|-> ##[2:6] !analog_power_on_r)
		else $error("path not powered down");
	AST_NO_PWR: assert property (!powered |-> !calibrating && !converting)
		else $error("activity while unpowered");
	AST_SHORT: assert property (input_short == (calibrating &&
		!calibration_source_select))
		else $error("input short control wrong");
	AST_UPLINK: assert property ($rose(converting) |-> ##[0:1] tx_to_uplink_r)
		else $error("transmit not routed to uplink");
	AST_VLD_ONE: assert property (baseband_serial_port_vld
		|=> !baseband_serial_port_vld)
		else $error("sample strobe longer than one cycle");
	cover property ($rose(converting));
	cover property (baseband_serial_port_vld);
	cover property (calibrating && $changed(offset_q));
endmodule // bdl_rx_props
bind bdl_rx_ctrl bdl_rx_props #(.SMP_W(SMP_W), .SETTLE_CYC(SETTLE_CYC))
	bdl_rx_props_i (.clk, .rst_n, .downlink_power_window,
	.calibration_source_select, .analog_power_on_r, .input_short,
	.tx_to_uplink_r, .baseband_serial_port_vld, .offset_i, .offset_q,
	.powered, .calibrating, .converting);
`default_nettype wire

// ==== verif/bdl_sd_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// Modulator stand-in: one word per channel every gap+1 cycles
module bdl_sd_model #(
	parameter logic [1:0] INT_I = 2'h3,
	parameter logic [1:0] INT_Q = 2'h1
) (
	input wire logic	clk,
	input wire logic [1:0]	gap,
	input wire logic [1:0]	lvl_i,
	input wire logic [1:0]	lvl_q,
	input wire logic	input_short,
	output var logic	sd_valid,
	output var logic [1:0]	sd_i_word,
	output var logic [1:0]	sd_q_word
);
	logic [1:0]	cnt_r = 2'h0;
	initial {sd_valid, sd_i_word, sd_q_word} = 5'h0;
	// Shorted inputs see only internal offset; words flip between strobes
	always @(posedge clk) begin
		cnt_r <= (cnt_r >= gap) ? 2'h0 : cnt_r + 2'h1;
		sd_valid <= (cnt_r >= gap);
		sd_i_word <= (cnt_r < gap) ? ~sd_i_word : input_short ? INT_I : lvl_i;
		sd_q_word <= (cnt_r < gap) ? ~sd_q_word : input_short ? INT_Q : lvl_q;
	end
endmodule // bdl_sd_model
`default_nettype wire

// ==== verif/tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic		clk = 0, rst_n = 0, ce = 1, pwr = 0, cal = 0, conv = 0, sel = 0;
	logic [1:0]	li = 0, lq = 0, gap = 0;
	logic [11:0]	ei = 0, eq = 0, si = 0, sq = 0;
	integer		miscompares = 0, samples_checked = 0, seed = 32'h31d4;
	integer		n, k, first, bl, t;
	wire		sd_valid, input_short, analog_power_on_r, tx_to_uplink_r;
	wire		baseband_serial_port_vld, powered, calibrating, converting;
	wire [1:0]	sd_i_word, sd_q_word;
	wire [11:0]	baseband_serial_port_i, baseband_serial_port_q;
	wire [11:0]	offset_i, offset_q;
	bdl_rx_ctrl #(.SETTLE_CYC(4)) bdl_rx_ctrl_i (.clk, .rst_n, .ce,
		.downlink_power_window(pwr), .downlink_calibration_window(cal),
		.downlink_conversion_window(conv), .calibration_source_select(sel),
		.sd_valid, .sd_i_word, .sd_q_word, .analog_power_on_r, .input_short,
		.tx_to_uplink_r, .baseband_serial_port_i, .baseband_serial_port_q,
		.baseband_serial_port_vld, .offset_i, .offset_q, .powered,
		.calibrating, .converting);
	bdl_sd_model bdl_sd_model_i (.clk, .gap, .lvl_i(li), .lvl_q(lq),
		.input_short, .sd_valid, .sd_i_word, .sd_q_word);
	initial forever #50 clk = ~clk;
	// Inputs move 1 ns after the edge, never on it
	task cyc(input integer c);
		repeat (c) @(posedge clk);
		#1;
	endtask
	function logic [11:0] blk(input logic [1:0] w);
		blk = 12'(24 * $signed(w));
	endfunction
	task chk(input logic [11:0] got, input logic [11:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Counts output pairs over c cycles, checking each against si and sq
	task watch(input integer c);
		k = 0;
		first = -1;
		for (t = 0; t < c; t++) begin
			cyc(1);
			if (baseband_serial_port_vld === 1'b1) begin
				if (first < 0) first = t;
				k++;
				chk(baseband_serial_port_i, si);
				chk(baseband_serial_port_q, sq);
			end
		end
	endtask
	task results;
		$display("checked %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Unpowered windows first, then randomised bursts, then a frozen clock enable, then a late reset
	initial begin
		cyc(6);
		rst_n = 1;
		cal = 1;
		conv = 1;
		watch(80);
		chk(12'(k), 0);
		chk(offset_i, 0);
		$display("unpowered test done");
		cal = 0;
		conv = 0;
		for (n = 0; n < 4; n++) begin
			gap = 2'({$random(seed)} % 3);
			bl = 24 * (gap + 1);
			sel = n[0];
			li = 2'($random(seed));
			lq = 2'($random(seed));
			pwr = 1;
			for (t = 0; t < 40 && powered !== 1'b1; t++)
				cyc(1);
			if (t == 40) begin
				miscompares++;
				results;
			end
			chk(12'(analog_power_on_r), 1);
			chk(offset_i, ei);
			cal = 1;
			watch(4 * bl);
			chk(12'(k), 0);
			chk(12'(calibrating), 1);
			chk(12'(input_short), 12'(!sel));
			cal = 0;
			cyc(6);
			ei = sel ? blk(li) : blk(2'h3);
			eq = sel ? blk(lq) : blk(2'h1);
			chk(offset_i, ei);
			chk(offset_q, eq);
			li = 2'($random(seed));
			lq = 2'($random(seed));
			si = blk(li) - ei;
			sq = blk(lq) - eq;
			conv = 1;
			watch(20 * bl);
			chk(12'(first >= 8 * bl && first < 10 * bl), 1);
			chk(12'(k >= 11 && k <= 12), 1);
			chk(12'(tx_to_uplink_r), 1);
			conv = 0;
			watch(3 * bl);
			chk(12'(k >= 1 && k <= 2), 1);
			chk(12'(tx_to_uplink_r), 0);
			chk(12'(converting), 0);
			chk(offset_i, ei);
			pwr = 0;
			cyc(8);
			chk(12'(analog_power_on_r), 0);
			$display("burst %0d done", n);
		end
		// Frozen clock enable must keep a power request from counting
		ce = 0;
		pwr = 1;
		cyc(20);
		chk(12'(analog_power_on_r), 0);
		pwr = 0;
		ce = 1;
		rst_n = 0;
		cyc(2);
		rst_n = 1;
		cyc(1);
		chk(offset_q, 0);
		$display("enable and reset test done");
		results;
	end
endmodule // tb
`default_nettype wire
